// [logic/fpus_top.sv]
// power-on and reset entry sequencer for the serial flash interface
module fpus_top
	import fpus_pkg::*;
#(
	parameter int unsigned WRITE_WAIT = WRITE_WAIT_CYCLES,
	parameter int unsigned READ_WAIT = READ_WAIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic core_so_out,
	input wire logic core_so_drive,
	output logic so_out,
	output logic so_oe_n,
	output logic cmd_enable,
	output logic read_allowed,
	output logic prog_erase_allowed,
	output logic spi_mode,
	output logic standby,
	output logic active
);
	import fpus_pkg::*;

	// reset release copy
	logic rst_m_r;
	logic rst_s_r;

	// synchronised pins
	// each lags its pin by four clk_sys edges: three stages plus the agreement register
	logic cs_n_s;
	logic sck_s;
	logic supply_s;

	// state
	// state and counters of the sequencer, all registered on clk_sys
	fpus_state_t state_r;
	fpus_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic cs_prev_r;
	logic cs_prev_nxt;
	logic armed_r; // a select fall has been seen since reset
	logic armed_nxt;
	logic mode_r;
	logic mode_nxt;
	// output pad registers
	logic so_r;
	logic so_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	// read window flag
	logic rd_ok_r;
	logic rd_ok_nxt;

	// two-flop release of the asynchronous reset
	// the release is taken in the clk_sys domain so every flop below
	// leaves reset on the same edge; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	// pin synchronisers; select idles high, clock idles low
	// all pins pass the same chain, so select and clock stay aligned
	// and the mode sample on a select fall sees a clock level of the same age
	fpus_sync #(.INIT(1'b1)) u_cs (
		.clk(clk_sys),
		.rst_n(rst_s_r),
		.din(chip_select_n),
		.dout(cs_n_s)
	);
	// clock level is only ever read as a level, never as an edge
	fpus_sync #(.INIT(1'b0)) u_sck (
		.clk(clk_sys),
		.rst_n(rst_s_r),
		.din(sck),
		.dout(sck_s)
	);
	// supply indicator; a dip of two clk_sys cycles or more lands in por once stages agree, a one-cycle dip is filtered
	fpus_sync #(.INIT(1'b0)) u_sup (
		.clk(clk_sys),
		.rst_n(rst_s_r),
		.din(supply_ok),
		.dout(supply_s)
	);

	// counter saturation check used for both waits
	// greater-or-equal keeps the wait safe should the counter overshoot;
	// the limit is cut to the counter width on purpose
	function automatic logic reached(input logic [CNT_W-1:0] c, input int unsigned lim);
		reached = (c >= lim[CNT_W-1:0]);
	endfunction : reached

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		cs_prev_nxt = cs_n_s;
		armed_nxt = armed_r;
		mode_nxt = mode_r;
		rd_ok_nxt = rd_ok_r;
		// defaults hold every register except cs_prev_r, which follows select; the state, a select fall and supply loss move the rest
		case (state_r)
			FPUS_POR: begin
				// held in reset while supply is low: nothing responds
				// counter and flags restart from zero on every ramp-up
				cnt_nxt = '0;
				armed_nxt = 1'b0;
				rd_ok_nxt = 1'b0;
				if (supply_s) begin
					state_nxt = FPUS_WAIT;
				end
			end
			FPUS_WAIT: begin
				// count saturates at the limit so the decision below stays stable
				if (!reached(cnt_r, WRITE_WAIT)) begin
					cnt_nxt = cnt_r + 1'b1;
				end
				// read window mirrors the host's own wait, for visibility only
				if (reached(cnt_r, READ_WAIT)) begin
					rd_ok_nxt = 1'b1;
				end
				if (reached(cnt_r, WRITE_WAIT)) begin
					// delay over: pick standby or active from select level
					state_nxt = cs_n_s ? FPUS_STANDBY : FPUS_ACTIVE;
				end
			end
			FPUS_STANDBY: begin
				// once the wait is over, select level moves the state, except that supply loss below sends it to por
				if (!cs_n_s) begin
					state_nxt = FPUS_ACTIVE;
				end
			end
			FPUS_ACTIVE: begin
				// raising select ends the active state at once
				if (cs_n_s) begin
					state_nxt = FPUS_STANDBY;
				end
			end
			default: begin
				// an unused code falls back to por rather than hanging
				state_nxt = FPUS_POR;
			end
		endcase
		// select falling edge: sample idle clock level for mode
		// ignored in por so a select made during ramp-up cannot arm
		// the interface before the device has come out of reset
		if (state_r != FPUS_POR && cs_prev_r && !cs_n_s) begin
			mode_nxt = sck_s ? MODE_3 : MODE_0;
			armed_nxt = 1'b1;
		end
		// supply loss drops straight back into reset
		// this overrides any state change above, including the end of the wait
		if (!supply_s) begin
			state_nxt = FPUS_POR;
		end
	end

	// output pin next values; floats until armed and core drives
	// the pad is released whenever select is high, so a host that
	// deselects mid-transfer never sees the pin fight its pull-up
	always_comb begin
		so_nxt = 1'b0;
		oe_n_nxt = 1'b1;
		if (armed_r && !cs_n_s && state_r != FPUS_POR && core_so_drive) begin
			// drive only inside an armed frame
			so_nxt = core_so_out;
			oe_n_nxt = 1'b0;
		end
	end

	// register all sequencer state
	// reset values match the idle levels of the pins, so no false
	// select edge appears when the internal reset lets go
	always_ff @(posedge clk_sys or negedge rst_s_r) begin
		if (!rst_s_r) begin
			state_r <= FPUS_POR;
			cnt_r <= '0;
			cs_prev_r <= 1'b1;
			armed_r <= 1'b0;
			mode_r <= MODE_0;
			so_r <= 1'b0;
			oe_n_r <= 1'b1;
			rd_ok_r <= 1'b0;
		end else begin
			// every register moves on every edge; no enable
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			cs_prev_r <= cs_prev_nxt;
			armed_r <= armed_nxt;
			mode_r <= mode_nxt;
			so_r <= so_nxt;
			oe_n_r <= oe_n_nxt;
			rd_ok_r <= rd_ok_nxt;
		end
	end

	// command gate: a fall must have been seen and reset left
	// the gate opens one cycle after a synced fall, so the mode register
	// already holds the clock level sampled on that very fall
	assign cmd_enable = armed_r && !cs_prev_r && !cs_n_s && (state_r != FPUS_POR);
	assign prog_erase_allowed = cmd_enable && (state_r != FPUS_WAIT);
	// limitation: the read window is an indication only; reads are not gated
	assign read_allowed = rd_ok_r;
	assign so_out = so_r;
	assign so_oe_n = oe_n_r;
	assign spi_mode = mode_r;
	assign standby = (state_r == FPUS_STANDBY);
	assign active = (state_r == FPUS_ACTIVE);
endmodule : fpus_top

// [include/fpus_pkg.sv]
// constants and types for the flash power-up sequencer
package fpus_pkg;
	// clock rate of clk_sys in kHz
	localparam int unsigned CLK_KHZ = 25000;
	// read wait after supply valid, microseconds
	localparam int unsigned READ_WAIT_AFTER_SUPPLY_US = 70;
	// read wait in cycles, a least time, rounded up
	localparam int unsigned READ_WAIT_CYCLES = (READ_WAIT_AFTER_SUPPLY_US * CLK_KHZ + 999) / 1000;
	// program/erase wait after power-up, milliseconds
	localparam int unsigned WRITE_WAIT_AFTER_POWERUP_MS = 3;
	// write wait in cycles, a longest time, an exact product with no rounding
	localparam int unsigned WRITE_WAIT_CYCLES = WRITE_WAIT_AFTER_POWERUP_MS * CLK_KHZ;
	// width of the power-up counter
	localparam int unsigned CNT_W = 17;
	// spi mode codes
	localparam logic MODE_0 = 1'b0;
	localparam logic MODE_3 = 1'b1;
	// sequencer states
	typedef enum logic [1:0] {
		FPUS_POR = 2'b00,
		FPUS_WAIT = 2'b01,
		FPUS_STANDBY = 2'b10,
		FPUS_ACTIVE = 2'b11
	} fpus_state_t;
endpackage : fpus_pkg

// [logic/fpus_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
module fpus_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic dout_r;
	logic dout_nxt;
	// only change when the second and third stage agree; first stage feeds nothing else
	always_comb begin
		dout_nxt = dout_r;
		if (s2_r == s3_r) begin
			dout_nxt = s2_r;
		end
	end
	// register the chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			dout_r <= INIT;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout_r <= dout_nxt;
		end
	end
	assign dout = dout_r;
endmodule : fpus_sync

// [tb/fpus_top_props.sv]
// port assertions for the power-up sequencer
module fpus_top_props #(
	parameter int unsigned WRITE_WAIT = 20,
	parameter int unsigned READ_WAIT = 5
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic core_so_out,
	input wire logic core_so_drive,
	input wire logic so_out,
	input wire logic so_oe_n,
	input wire logic cmd_enable,
	input wire logic read_allowed,
	input wire logic prog_erase_allowed,
	input wire logic spi_mode,
	input wire logic standby,
	input wire logic active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_float; !supply_ok [*7] |-> so_oe_n; endproperty
	a_float: assert property (p_float) else $error("so driven in por");
	property p_nosel; chip_select_n [*8] |-> !cmd_enable; endproperty
	a_nosel: assert property (p_nosel) else $error("cmd without select");
	property p_mode; $rose(cmd_enable) |-> spi_mode == sck; endproperty
	a_mode: assert property (p_mode) else $error("wrong spi mode");
	property p_por; !supply_ok [*7] |-> !(cmd_enable | read_allowed | standby | active); endproperty
	a_por: assert property (p_por) else $error("busy in por");
	property p_pe; $rose(supply_ok) |=> !prog_erase_allowed [*8]; endproperty
	a_pe: assert property (p_pe) else $error("early program");
	property p_end; $rose(standby | active) |-> standby == chip_select_n; endproperty
	a_end: assert property (p_end) else $error("wrong end state");
endmodule : fpus_top_props
bind fpus_top fpus_top_props #(.WRITE_WAIT(WRITE_WAIT), .READ_WAIT(READ_WAIT)) chk_u (.*);

// [tb/fpus_host.sv]
// host model: parks the clock, reads only after the read wait
module fpus_host #(
	parameter int unsigned RD = 5
) (
	input wire logic clk_sys,
	input wire logic supply_ok,
	input wire logic start,
	input wire logic mode,
	output logic chip_select_n,
	output logic sck
);
	timeunit 1ns;
	timeprecision 1ns;
	int up = 0; // cycles since supply came up
	initial begin
		chip_select_n = 1'b1;
		sck = 1'b0;
	end
	// clock stands at its idle level; select falls to open a frame
	always @(posedge clk_sys) begin
		up <= supply_ok ? up + 1 : 0;
		sck <= #1 mode;
		// a select while supply is low is a probe that the device ignores
		chip_select_n <= #1 !(start && (up > RD || !supply_ok));
	end
endmodule : fpus_host

// [tb/fpus_top_test.sv]
// self-checking bench for the power-up sequencer
module fpus_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned WR = 20; // shortened program/erase wait
	logic clk_sys = 1'b0, rst_n = 1'b0, supply_ok = 1'b0, core_so_out = 1'b1;
	logic core_so_drive = 1'b1, start = 1'b0, mode = 1'b0, chip_select_n, sck;
	logic so_out, so_oe_n, cmd_enable, read_allowed, prog_erase_allowed, spi_mode;
	logic standby, active;
	int n_fail = 0, num_checks = 0, i;
	always #20 clk_sys = ~clk_sys;
	fpus_host #(.RD(5)) host_u (.*);
	fpus_top #(.WRITE_WAIT(WR), .READ_WAIT(5)) dut_u (.*);
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task chk(logic a, logic e);
		num_checks++;
		if (a !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t %h %h", $time, a, e);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	task lim;
		if (i >= 200) begin
			n_fail++;
			report_and_stop;
		end
	endtask : lim
	task t_por;
		supply_ok = 1'b0;
		start = 1'b1;
		cyc(12);
		chk(so_oe_n, 1'b1);
		chk(cmd_enable | read_allowed | standby | active, 1'b0);
		start = 1'b0;
	endtask : t_por
	task t_up(logic s);
		start = s;
		supply_ok = 1'b1;
		for (i = 0; i < 200 && !(standby | active); i++) begin
			chk(prog_erase_allowed, 1'b0);
			cyc(1);
		end
		lim;
		chk(i >= WR, 1'b1);
		chk(prog_erase_allowed, s);
		chk(active, s);
		chk(standby, !s);
		chk(read_allowed, 1'b1);
	endtask : t_up
	task t_sel(logic m);
		mode = m;
		core_so_out = m;
		cyc(4);
		start = 1'b1;
		for (i = 0; i < 200 && cmd_enable !== 1'b1; i++) cyc(1);
		lim;
		chk(spi_mode, m);
		cyc(1);
		chk(so_oe_n, 1'b0);
		chk(so_out, m);
		core_so_drive = 1'b0;
		cyc(1);
		chk(so_oe_n, 1'b1);
		core_so_drive = 1'b1;
		start = 1'b0;
		cyc(8);
		chk(cmd_enable, 1'b0);
	endtask : t_sel
	initial begin
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		t_por;
		t_up(1'b0);
		t_sel(1'b1);
		t_sel(1'b0);
		t_por;
		t_up(1'b1);
		report_and_stop;
	end
endmodule : fpus_top_test
